// >>> verilog/ckr_pkg.sv
/*
 * ckr_pkg: constants for the clock output and memory-interface clock select block.
 * Assumes a single 50 MHz system clock and a plain register port.
 */
package ckr_pkg;
    localparam logic [31:0] DEVICE_CONFIG_OFFSET = 32'h019c0200;
    localparam logic [31:0] MEMIF_GLOBAL_CONTROL_OFFSET = 32'h019c0300;
    localparam logic [31:0] GPIO_ENABLE_OFFSET = 32'h019c0400;
    localparam logic [31:0] GPIO_DIRECTION_OFFSET = 32'h019c0404;
    localparam logic [31:0] GPIO_DATA_OFFSET = 32'h019c0408;
    localparam int CLOCK_SOURCE_BIT = 4;
    localparam int FULL_RATE_ENABLE_BIT = 4;
    localparam int HALF_RATE_ENABLE_BIT = 3;
    localparam int GPIO_TWO_BIT = 2;
    localparam logic [31:0] DEVICE_CONFIG_MASK = 32'h00000010;
    localparam logic [31:0] GLOBAL_CONTROL_MASK = 32'h00000018;
    localparam logic [31:0] GPIO_MASK = 32'h00000004;
    localparam logic [31:0] DEVICE_CONFIG_RESET = 32'h00000000;
    localparam logic [31:0] GLOBAL_CONTROL_RESET = 32'h00000018;
    localparam logic [31:0] GPIO_RESET = 32'h00000000;
    localparam logic [31:0] READ_ZERO = 32'h00000000;
endpackage

// >>> verilog/ckr_sync.sv
/*
 * ckr_sync: two flip-flop synchroniser for one level from outside the clock domain.
 * Assumes the input is a slow level; pulses shorter than one clock may be lost.
 */
`timescale 1ns/10ps
module ckr_sync
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;

    always_comb
    begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta_q <= 1'h0;
            sync_q <= 1'h0;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule // ckr_sync

// >>> verilog/ckr_clock_route.sv
/*
 * ckr_clock_route: memory-interface clock source select, full- and half-rate clock
 * outputs, and the half-rate pin shared with gpio line two.
 * Assumes generator clocks arrive from the on-chip clock generator and the
 * register port is driven on the rising edge of clock.
 */
`timescale 1ns/10ps
module ckr_clock_route
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [31:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    input wire logic core_clock,
    input wire logic generator_clock_b,
    input wire logic generator_clock_c,
    input wire logic external_memory_clock_pin,
    output logic memif_clock,
    output logic full_rate_clock_out,
    input wire logic half_rate_pin_in,
    output logic half_rate_pin_out,
    output logic half_rate_pin_oe_b
);
    // software-visible registers
    logic [31:0] device_config_q;
    logic [31:0] device_config_d;
    logic [31:0] global_ctl_q;
    logic [31:0] global_ctl_d;
    logic [31:0] gpio_en_q;
    logic [31:0] gpio_en_d;
    logic [31:0] gpio_dir_q;
    logic [31:0] gpio_dir_d;
    logic [31:0] gpio_out_q;
    logic [31:0] gpio_out_d;

    // read path
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    // pin and mode
    logic pin_sync;
    logic gpio_mode;
    logic clock_source_pin;
    logic full_rate_enable;
    logic half_rate_enable;

    function automatic logic hit(input logic [31:0] addr, input logic [31:0] offset);
        hit = (addr == offset);
    endfunction

    // pin level is asynchronous to clock, resynchronise before software sees it
    ckr_sync u_pin_sync
    (
        .clock(clock),
        .rst_b(rst_b),
        .async_in(half_rate_pin_in),
        .sync_out(pin_sync)
    );

    // reserved bits are masked off so stray writes cannot reach them
    always_comb
    begin
        device_config_d = device_config_q;
        global_ctl_d = global_ctl_q;
        gpio_en_d = gpio_en_q;
        gpio_dir_d = gpio_dir_q;
        gpio_out_d = gpio_out_q;
        if (reg_write)
        begin
            if (hit(reg_addr, ckr_pkg::DEVICE_CONFIG_OFFSET))
                device_config_d = reg_wdata & ckr_pkg::DEVICE_CONFIG_MASK;
            if (hit(reg_addr, ckr_pkg::MEMIF_GLOBAL_CONTROL_OFFSET))
                global_ctl_d = reg_wdata & ckr_pkg::GLOBAL_CONTROL_MASK;
            if (hit(reg_addr, ckr_pkg::GPIO_ENABLE_OFFSET))
                gpio_en_d = reg_wdata & ckr_pkg::GPIO_MASK;
            if (hit(reg_addr, ckr_pkg::GPIO_DIRECTION_OFFSET))
                gpio_dir_d = reg_wdata & ckr_pkg::GPIO_MASK;
            if (hit(reg_addr, ckr_pkg::GPIO_DATA_OFFSET))
                gpio_out_d = reg_wdata & ckr_pkg::GPIO_MASK;
        end
    end

    // gpio data bit reads the pin, not the output latch, so a released pin shows the board
    always_comb
    begin
        rdata_d = ckr_pkg::READ_ZERO;
        if (reg_read)
        begin
            if (hit(reg_addr, ckr_pkg::DEVICE_CONFIG_OFFSET))
                rdata_d = device_config_q;
            else if (hit(reg_addr, ckr_pkg::MEMIF_GLOBAL_CONTROL_OFFSET))
                rdata_d = global_ctl_q;
            else if (hit(reg_addr, ckr_pkg::GPIO_ENABLE_OFFSET))
                rdata_d = gpio_en_q;
            else if (hit(reg_addr, ckr_pkg::GPIO_DIRECTION_OFFSET))
                rdata_d = gpio_dir_q;
            else if (hit(reg_addr, ckr_pkg::GPIO_DATA_OFFSET))
            begin
                rdata_d = gpio_out_q;
                rdata_d[ckr_pkg::GPIO_TWO_BIT] = pin_sync;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            device_config_q <= ckr_pkg::DEVICE_CONFIG_RESET;
            global_ctl_q <= ckr_pkg::GLOBAL_CONTROL_RESET;
            gpio_en_q <= ckr_pkg::GPIO_RESET;
            gpio_dir_q <= ckr_pkg::GPIO_RESET;
            gpio_out_q <= ckr_pkg::GPIO_RESET;
            rdata_q <= ckr_pkg::READ_ZERO;
        end
        else
        begin
            device_config_q <= device_config_d;
            global_ctl_q <= global_ctl_d;
            gpio_en_q <= gpio_en_d;
            gpio_dir_q <= gpio_dir_d;
            gpio_out_q <= gpio_out_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // control bits decoded once, shared by the clock paths and the checks
    assign clock_source_pin = device_config_q[ckr_pkg::CLOCK_SOURCE_BIT];
    assign full_rate_enable = global_ctl_q[ckr_pkg::FULL_RATE_ENABLE_BIT];
    assign half_rate_enable = global_ctl_q[ckr_pkg::HALF_RATE_ENABLE_BIT];
    assign gpio_mode = gpio_en_q[ckr_pkg::GPIO_TWO_BIT];

    // clock paths are pure muxing and gating; a glitch on switch is the user's risk
    assign memif_clock = clock_source_pin ?
        external_memory_clock_pin : generator_clock_c;
    assign full_rate_clock_out = core_clock & full_rate_enable;

    // disabled half-rate clock releases the pin to its pull-down rather than driving low
    always_comb
    begin
        if (gpio_mode)
        begin
            half_rate_pin_out = gpio_out_q[ckr_pkg::GPIO_TWO_BIT];
            half_rate_pin_oe_b = !gpio_dir_q[ckr_pkg::GPIO_TWO_BIT];
        end
        else
        begin
            half_rate_pin_out = generator_clock_b;
            half_rate_pin_oe_b = !half_rate_enable;
        end
    end

    // checks sample at the system clock; the clock paths are combinational so both sides agree
    source_sel_a: assert property (@(posedge clock) disable iff (!rst_b)
        reg_write && hit(reg_addr, ckr_pkg::DEVICE_CONFIG_OFFSET) |=>
        device_config_q[ckr_pkg::CLOCK_SOURCE_BIT] == $past(reg_wdata[ckr_pkg::CLOCK_SOURCE_BIT]))
        else $error("clock source bit did not follow write");

    reserved_zero_a: assert property (@(posedge clock) disable iff (!rst_b)
        (device_config_q & ~ckr_pkg::DEVICE_CONFIG_MASK) == ckr_pkg::READ_ZERO)
        else $error("reserved config bits not zero");

    full_gate_a: assert property (@(posedge clock) disable iff (!rst_b)
        !full_rate_enable |-> !full_rate_clock_out)
        else $error("full-rate clock active while disabled");

    full_clock_a: assert property (@(posedge clock) disable iff (!rst_b)
        full_rate_enable |-> full_rate_clock_out == core_clock)
        else $error("full-rate pin not carrying core clock");

    half_gate_a: assert property (@(posedge clock) disable iff (!rst_b)
        !gpio_mode && !half_rate_enable |-> half_rate_pin_oe_b)
        else $error("half-rate pin driven while disabled");

    half_drive_a: assert property (@(posedge clock) disable iff (!rst_b)
        !gpio_mode && half_rate_enable |-> !half_rate_pin_oe_b)
        else $error("half-rate pin released while enabled");

    half_clock_a: assert property (@(posedge clock) disable iff (!rst_b)
        !gpio_mode |-> half_rate_pin_out == generator_clock_b)
        else $error("half-rate pin not carrying generator clock b");

    gpio_drive_a: assert property (@(posedge clock) disable iff (!rst_b)
        gpio_mode |-> half_rate_pin_oe_b == !gpio_dir_q[ckr_pkg::GPIO_TWO_BIT])
        else $error("gpio direction not honoured");

    gpio_value_a: assert property (@(posedge clock) disable iff (!rst_b)
        gpio_mode |-> half_rate_pin_out == gpio_out_q[ckr_pkg::GPIO_TWO_BIT])
        else $error("gpio output value not on pin");

    read_back_a: assert property (@(posedge clock) disable iff (!rst_b)
        reg_read && hit(reg_addr, ckr_pkg::DEVICE_CONFIG_OFFSET) |=> reg_rdata == $past(device_config_q))
        else $error("config read data wrong");

    gpio_read_a: assert property (@(posedge clock) disable iff (!rst_b)
        reg_read && hit(reg_addr, ckr_pkg::GPIO_DATA_OFFSET) |=> reg_rdata[ckr_pkg::GPIO_TWO_BIT] == $past(pin_sync))
        else $error("gpio data read does not show pin level");

    rdata_idle_a: assert property (@(posedge clock) disable iff (!rst_b)
        !reg_read |=> reg_rdata == ckr_pkg::READ_ZERO)
        else $error("read data held past its cycle");

    mem_clock_a: assert property (@(posedge clock) disable iff (!rst_b)
        !clock_source_pin |-> memif_clock == generator_clock_c)
        else $error("memory clock not from generator");

    mem_pin_a: assert property (@(posedge clock) disable iff (!rst_b)
        clock_source_pin |-> memif_clock == external_memory_clock_pin)
        else $error("memory clock not from external pin");
endmodule // ckr_clock_route

// >>> test/ckr_board_model.sv
/*
 * ckr_board_model: board clock sources and the load on the shared half-rate pin.
 * Assumes the pin comes split into drive value and active-low enable.
 */
`timescale 1ns/10ps
module ckr_board_model
(
    input wire logic ext_drive,
    input wire logic ext_value,
    input wire logic pin_out,
    input wire logic pin_oe_b,
    output logic pin_level,
    output logic core_c,
    output logic gen_b,
    output logic gen_c,
    output logic ext_c
);
    initial {core_c, gen_b, gen_c, ext_c} = 4'h0;
    // half periods of 7, 14, 9 and 11 ns keep every source out of step with the bench clock
    always #7 core_c = ~core_c;
    always #14 gen_b = ~gen_b;
    always #9 gen_c = ~gen_c;
    always #11 ext_c = ~ext_c;
    // pull-down holds a released, undriven pin low
    assign pin_level = !pin_oe_b ? pin_out : (ext_drive ? ext_value : 1'b0);
endmodule // ckr_board_model

// >>> test/tb_top.sv
/*
 * tb_top: self-checking bench for ckr_clock_route beside the board model.
 * Assumes read data stand only in the cycle after the read strobe.
 */
`timescale 1ns/10ps
module tb_top;
    typedef struct {logic [31:0] a; logic [31:0] w; logic [31:0] r;} ckr_row_t;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [31:0] reg_addr = 32'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic ext_drive = 1'b0;
    logic ext_value = 1'b0;
    logic [31:0] reg_rdata;
    logic core_c, gen_b, gen_c, ext_c, memif_clock, full_out, pin_level, pin_out, pin_oe_b;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    ckr_row_t rows [9];
    always #10 clock = ~clock;
    ckr_clock_route uut (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .core_clock(core_c),
        .generator_clock_b(gen_b), .generator_clock_c(gen_c), .external_memory_clock_pin(ext_c),
        .memif_clock(memif_clock), .full_rate_clock_out(full_out), .half_rate_pin_in(pin_level),
        .half_rate_pin_out(pin_out), .half_rate_pin_oe_b(pin_oe_b));
    ckr_board_model board (.ext_drive(ext_drive), .ext_value(ext_value), .pin_out(pin_out),
        .pin_oe_b(pin_oe_b), .pin_level(pin_level), .core_c(core_c), .gen_b(gen_b), .gen_c(gen_c),
        .ext_c(ext_c));
    task automatic end_of_test();
        if (num_errors == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 cmp(reg_rdata, exp);
        @(posedge clock);
        #1 cmp(reg_rdata, 32'h0);
    endtask
    // sample steps of 3.3 ns never land on a source edge
    task automatic chk_clk(input logic sel, input logic en1, input logic en2);
        repeat (8)
        begin
            #3.3 cmp(memif_clock, sel ? ext_c : gen_c);
            cmp(full_out, en1 & core_c);
            cmp(pin_oe_b, !en2);
            if (en2)
                cmp(pin_out, gen_b);
        end
    endtask
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            num_errors++;
            end_of_test();
        end
    end
    initial
    begin
        // config writes keep its reserved bits zero, as software must
        rows = '{'{32'h019c0400, '1, 32'h4}, '{32'h019c0400, 32'h0, 32'h0}, '{32'h019c0404, '1, 32'h4},
            '{32'h019c0404, 32'h0, 32'h0}, '{32'h019c0300, 32'h0, 32'h0}, '{32'h019c0300, '1, 32'h18},
            '{32'h019c0200, 32'h10, 32'h10}, '{32'h019c0200, 32'h0, 32'h0}, '{32'h019c0204, 32'h10, 32'h0}};
        repeat (6) @(posedge clock);
        rst_b <= 1'b1;
        rd(32'h019c0200, ckr_pkg::DEVICE_CONFIG_RESET);
        rd(32'h019c0300, ckr_pkg::GLOBAL_CONTROL_RESET);
        rd(32'h019c0400, ckr_pkg::GPIO_RESET);
        chk_clk(1'b0, 1'b1, 1'b1);
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a, rows[i].r);
        end
        wr(32'h019c0200, 32'h10);
        chk_clk(1'b1, 1'b1, 1'b1);
        wr(32'h019c0300, 32'h0);
        chk_clk(1'b1, 1'b0, 1'b0);
        wr(32'h019c0300, 32'h8);
        chk_clk(1'b1, 1'b0, 1'b1);
        wr(32'h019c0400, 32'h4);
        wr(32'h019c0404, 32'h4);
        wr(32'h019c0408, 32'h4);
        #1 cmp({pin_oe_b, pin_out}, 32'h1);
        wr(32'h019c0404, 32'h0);
        // output latch cleared so only the pin can put a one in the read data
        wr(32'h019c0408, 32'h0);
        ext_drive <= 1'h1;
        ext_value <= 1'h1;
        repeat (3) @(posedge clock);
        rd(32'h019c0408, 32'h4);
        cmp(pin_oe_b, 32'h1);
        ext_value <= 1'h0;
        repeat (3) @(posedge clock);
        rd(32'h019c0408, 32'h0);
        // mid-run reset must bring back the clock function and the config and gpio enable defaults
        ext_drive <= 1'h0;
        wr(32'h019c0200, 32'h10);
        @(posedge clock);
        rst_b <= 1'h0;
        @(posedge clock);
        rst_b <= 1'h1;
        rd(32'h019c0200, ckr_pkg::DEVICE_CONFIG_RESET);
        rd(32'h019c0400, ckr_pkg::GPIO_RESET);
        chk_clk(1'h0, 1'h1, 1'h1);
        end_of_test();
    end
endmodule // tb_top
